// ### logic/pccs_map.vh
// constants of the counter and phase-select logic of the clock synthesizer
`ifndef PCCS_MAP_VH
`define PCCS_MAP_VH

// ----------------------------------------------------------------------
// legal counter settings
// ----------------------------------------------------------------------
`define PCCS_MULT_MIN 6'h02
`define PCCS_MULT_MAX 6'h20
`define PCCS_DIV_MIN 6'h01
`define PCCS_DIV_MAX 6'h20

// ----------------------------------------------------------------------
// oscillator model and lock detection
// ----------------------------------------------------------------------
// number of equally spaced oscillator phase taps
`define PCCS_TAP_COUNT 8
// last tap index, one oscillator period ends after it
`define PCCS_TAP_LAST 3'h7
// clk cycles per tap step after counter reset (nominal oscillator)
`define PCCS_NOMINAL_TAP_LEN 8'h04
`define PCCS_TAP_LEN_MIN 8'h01
`define PCCS_TAP_LEN_MAX 8'hFF
// matching reference windows needed before lock is shown
`define PCCS_LOCK_COUNT 4'h8
// saturation of the oscillator period count in one reference window
`define PCCS_PERIOD_SAT 6'h3F

// ----------------------------------------------------------------------
// bus positions of the three post-scale counters
// ----------------------------------------------------------------------
`define PCCS_IDX_CORE_A 0
`define PCCS_IDX_CORE_B 1
`define PCCS_IDX_EXT 2

`endif

// ### logic/pccs_post_counter.v
// one post-scale counter: tap-clocked divider with initial count and duty setting
`include "pccs_map.vh"

module pccs_post_counter (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // common start control
  input wire hold,
  // selected tap edges
  input wire rise_edge,
  input wire half_edge,
  // counter setup, the three counts in half oscillator periods, plus output inversion
  input wire [6:0] div_half,
  input wire [6:0] high_half,
  input wire [6:0] start_half,
  input wire invert,
  // divided clock
  output wire clk_out
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg armed_q; // set at the first rising tap edge after release
  reg [6:0] cnt_q; // half-period position inside the output period
  reg out_q; // registered output level
  reg [6:0] cnt_d; // next position on a half edge

  // wrap at the end of the output period
  always @* begin
    if (cnt_q >= div_half - 7'h01) begin
      cnt_d = 7'h00;
    end else begin
      cnt_d = cnt_q + 7'h01;
    end
  end

  // counting process
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_q <= 1'b0;
      cnt_q <= 7'h00;
      out_q <= 1'b0;
    end else if (hold) begin
      armed_q <= 1'b0;
      cnt_q <= start_half;
      out_q <= 1'b0;
    end else if (!armed_q) begin
      if (rise_edge) begin
        armed_q <= 1'b1;
        cnt_q <= start_half;
        out_q <= (start_half < high_half) ^ invert;
      end
    end else if (half_edge) begin
      cnt_q <= cnt_d;
      out_q <= (cnt_d < high_half) ^ invert;
    end
  end

  assign clk_out = out_q;

endmodule // pccs_post_counter

// ### logic/pccs_top.v
// counter, phase-tap and lock logic of the on-chip clock synthesizer
`include "pccs_map.vh"

module pccs_top #(
  parameter LEN_W = 8, // width of the tap step length
  parameter [7:0] NOMINAL_TAP_LEN = `PCCS_NOMINAL_TAP_LEN // tap length after reset
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // loop control from core logic
  input wire counter_reset,
  input wire run_enable,
  input wire pd_gate,
  // reference clock pin
  input wire ref_clk_pin,
  // loop settings
  input wire [5:0] prescale_value,
  input wire [5:0] mult_value,
  // core_post_divider_a setup
  input wire [5:0] core_post_divider_a_value,
  input wire [6:0] core_post_divider_a_high,
  input wire [6:0] core_post_divider_a_low,
  input wire [5:0] core_post_divider_a_init,
  input wire [2:0] core_post_divider_a_tap,
  input wire core_post_divider_a_invert,
  // core_post_divider_b setup
  input wire [5:0] core_post_divider_b_value,
  input wire [6:0] core_post_divider_b_high,
  input wire [6:0] core_post_divider_b_low,
  input wire [5:0] core_post_divider_b_init,
  input wire [2:0] core_post_divider_b_tap,
  input wire core_post_divider_b_invert,
  // external post divider setup
  input wire [5:0] ext_post_divider_value,
  input wire [6:0] ext_post_divider_high,
  input wire [6:0] ext_post_divider_low,
  input wire [5:0] ext_post_divider_init,
  input wire [2:0] ext_post_divider_tap,
  input wire ext_post_divider_invert,
  // core output routing, 0 picks divider a, 1 picks divider b
  input wire core_clock_out_a_sel,
  input wire core_clock_out_b_sel,
  // external pin sharing
  input wire ext_clock_used,
  input wire gpio_out,
  input wire gpio_oe,
  input wire ext_pin_in,
  output wire ext_pin_out,
  output wire ext_pin_oe,
  output wire gpio_in,
  // synthesized core clocks
  output wire core_clock_out_a,
  output wire core_clock_out_b,
  // status
  output wire locked,
  output wire [LEN_W-1:0] osc_tap_len
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // clamp a setting into its legal range
  function [5:0] clamp6;
    input [5:0] v;
    input [5:0] lo;
    input [5:0] hi;
    begin
      if (v < lo) begin
        clamp6 = lo;
      end else if (v > hi) begin
        clamp6 = hi;
      end else begin
        clamp6 = v;
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // settings and common hold
  // ----------------------------------------------------------------------
  wire [5:0] mult_eff; // legal feedback multiplier
  wire [5:0] pre_eff; // legal pre-scale value
  wire hold; // dividers and outputs held at initial state

  assign mult_eff = clamp6(mult_value, `PCCS_MULT_MIN, `PCCS_MULT_MAX);
  assign pre_eff = clamp6(prescale_value, `PCCS_DIV_MIN, `PCCS_DIV_MAX);
  assign hold = counter_reset | ~run_enable;

  // ----------------------------------------------------------------------
  // reference pin synchronizer and pre-scale divider
  // ----------------------------------------------------------------------
  reg ref_meta_q; // first stage, read only by ref_sync_q
  reg ref_sync_q; // second stage
  reg ref_last_q; // previous synchronized level for edge detect
  reg [5:0] pre_cnt_q; // reference edges seen in this pre-scale cycle
  wire ref_rise; // one rising reference edge
  wire ref_tick; // divided reference edge to the detector

  // two flip-flops before any logic looks at the pin
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_meta_q <= 1'b0;
      ref_sync_q <= 1'b0;
      ref_last_q <= 1'b0;
    end else begin
      ref_meta_q <= ref_clk_pin;
      ref_sync_q <= ref_meta_q;
      ref_last_q <= ref_sync_q;
    end
  end

  assign ref_rise = ref_sync_q & ~ref_last_q;
  assign ref_tick = ref_rise & (pre_cnt_q >= pre_eff - 6'h01);

  // pre-scale counter restarts with the counters
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_q <= 6'h00;
    end else if (hold) begin
      pre_cnt_q <= 6'h00;
    end else if (ref_tick) begin
      pre_cnt_q <= 6'h00;
    end else if (ref_rise) begin
      pre_cnt_q <= pre_cnt_q + 6'h01;
    end
  end

  // ----------------------------------------------------------------------
  // oscillator model: eight taps stepped every tap_len_q clk cycles
  // ----------------------------------------------------------------------
  reg [LEN_W-1:0] tap_len_q; // clk cycles between adjacent taps
  reg [LEN_W-1:0] len_cnt_q; // position inside one tap step
  reg [2:0] osc_phase_q; // tap index that last fired
  wire tap_step; // a tap fires in this cycle
  wire [2:0] phase_next; // tap index that fires now
  wire osc_wrap; // one oscillator period completed

  // the step is one clk cycle resolution, so the model only tracks
  // reference clocks far below clk; it is not a real oscillator
  assign tap_step = (len_cnt_q >= tap_len_q - {{(LEN_W-1){1'b0}}, 1'b1});
  assign phase_next = osc_phase_q + 3'h1;
  assign osc_wrap = tap_step & (osc_phase_q == `PCCS_TAP_LAST);
  assign osc_tap_len = tap_len_q;

  // tap sequencer, frozen in hold so all dividers restart in step
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      len_cnt_q <= {LEN_W{1'b0}};
      osc_phase_q <= `PCCS_TAP_LAST;
    end else if (hold) begin
      len_cnt_q <= {LEN_W{1'b0}};
      osc_phase_q <= `PCCS_TAP_LAST;
    end else if (tap_step) begin
      // one tap is an eighth period
      len_cnt_q <= {LEN_W{1'b0}};
      osc_phase_q <= phase_next;
    end else begin
      len_cnt_q <= len_cnt_q + {{(LEN_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------------
  // frequency detector and lock
  // ----------------------------------------------------------------------
  reg [5:0] per_cnt_q; // oscillator periods in this reference window
  reg have_ref_q; // a window is open
  reg [3:0] streak_q; // matching windows in a row
  reg locked_q; // lock indication

  // period count per reference window, saturating
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt_q <= 6'h00;
    end else if (hold) begin
      per_cnt_q <= 6'h00;
    end else if (ref_tick) begin
      // a wrap in the tick cycle belongs to the new window
      per_cnt_q <= osc_wrap ? 6'h01 : 6'h00;
    end else if (osc_wrap && per_cnt_q != `PCCS_PERIOD_SAT) begin
      per_cnt_q <= per_cnt_q + 6'h01;
    end
  end

  // compare against the multiplier at each divided reference edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tap_len_q <= NOMINAL_TAP_LEN;
      have_ref_q <= 1'b0;
      streak_q <= 4'h0;
      locked_q <= 1'b0;
    end else if (counter_reset) begin
      tap_len_q <= NOMINAL_TAP_LEN;
      have_ref_q <= 1'b0;
      streak_q <= 4'h0;
      locked_q <= 1'b0;
    end else if (!run_enable) begin
      have_ref_q <= 1'b0;
      streak_q <= 4'h0;
      locked_q <= 1'b0;
    end else if (ref_tick) begin
      have_ref_q <= 1'b1;
      if (have_ref_q) begin
        if (per_cnt_q == mult_eff) begin
          if (streak_q != `PCCS_LOCK_COUNT) begin
            streak_q <= streak_q + 4'h1;
          end
          locked_q <= (streak_q + 4'h1 >= `PCCS_LOCK_COUNT);
        end else begin
          streak_q <= 4'h0;
          locked_q <= 1'b0;
          if (pd_gate) begin
            // steer oscillator to input times M over N
            if (per_cnt_q > mult_eff) begin
              if (tap_len_q != `PCCS_TAP_LEN_MAX) begin
                tap_len_q <= tap_len_q + {{(LEN_W-1){1'b0}}, 1'b1};
              end
            end else if (tap_len_q != `PCCS_TAP_LEN_MIN) begin
              tap_len_q <= tap_len_q - {{(LEN_W-1){1'b0}}, 1'b1};
            end
          end
        end
      end
    end
  end

  assign locked = locked_q;

  // ----------------------------------------------------------------------
  // three post-scale counters
  // ----------------------------------------------------------------------
  wire [17:0] div_bus; // divide values, counter i at [i*6 +: 6]
  wire [20:0] high_bus; // high counts in half periods
  wire [20:0] low_bus; // low counts in half periods
  wire [17:0] init_bus; // initial counts in whole periods
  wire [8:0] tap_bus; // tap selects
  wire [2:0] inv_bus; // output inversion
  wire [2:0] cnt_out; // divided clocks

  assign div_bus = {ext_post_divider_value, core_post_divider_b_value, core_post_divider_a_value};
  assign high_bus = {ext_post_divider_high, core_post_divider_b_high, core_post_divider_a_high};
  assign low_bus = {ext_post_divider_low, core_post_divider_b_low, core_post_divider_a_low};
  assign init_bus = {ext_post_divider_init, core_post_divider_b_init, core_post_divider_a_init};
  assign tap_bus = {ext_post_divider_tap, core_post_divider_b_tap, core_post_divider_a_tap};
  assign inv_bus = {ext_post_divider_invert, core_post_divider_b_invert,
                    core_post_divider_a_invert};

  // same phase logic for every divider
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_post
      wire [5:0] div_c; // legal divide value
      wire [6:0] div_half; // period in half oscillator periods
      wire [7:0] sum_hl; // requested high plus low
      wire [6:0] high_max; // longest producible high time
      wire [6:0] high_req; // high time after the sum check
      wire [6:0] high_eff; // high time in range
      wire [5:0] init_c; // initial count inside the period
      wire [2:0] tap_sel; // tap this divider counts on
      wire rise_edge; // rising edge of the selected tap
      wire half_edge; // either edge of the selected tap

      assign div_c = clamp6(div_bus[gi*6 +: 6], `PCCS_DIV_MIN, `PCCS_DIV_MAX);
      // half-period steps, twice the divide value
      assign div_half = {div_c, 1'b0};
      assign sum_hl = {1'b0, high_bus[gi*7 +: 7]} + {1'b0, low_bus[gi*7 +: 7]};
      assign high_max = (div_c == `PCCS_DIV_MIN) ? 7'h01 : div_half - 7'h02;
      // bad sum falls back to 50 percent
      assign high_req = (sum_hl == {1'b0, div_half}) ? high_bus[gi*7 +: 7] : {1'b0, div_c};
      assign high_eff = (high_req == 7'h00) ? 7'h01 :
                        (high_req > high_max) ? high_max : high_req;
      assign init_c = (init_bus[gi*6 +: 6] >= div_c) ? div_c - 6'h01 : init_bus[gi*6 +: 6];
      assign tap_sel = tap_bus[gi*3 +: 3];
      assign rise_edge = tap_step & (phase_next == tap_sel);
      assign half_edge = tap_step & (phase_next[1:0] == tap_sel[1:0]);

      // init and tap span the period
      pccs_post_counter u_post (
        .clk (clk),
        .rst_b (rst_b),
        .hold (hold),
        .rise_edge (rise_edge),
        .half_edge (half_edge),
        .div_half (div_half),
        .high_half (high_eff),
        .start_half ({init_c, 1'b0}),
        .invert (inv_bus[gi]),
        .clk_out (cnt_out[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // output routing and external pin sharing
  // ----------------------------------------------------------------------
  reg core_a_q; // core output a
  reg core_b_q; // core output b
  reg pin_out_q; // external pin level
  reg pin_oe_q; // external pin drive enable
  reg gpio_meta_q; // first stage, read only by gpio_sync_q
  reg gpio_sync_q; // synchronized pin input

  // registered outputs; held dividers already show low
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_a_q <= 1'b0;
      core_b_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      // either core output, either core divider
      core_a_q <= core_clock_out_a_sel ? cnt_out[`PCCS_IDX_CORE_B] : cnt_out[`PCCS_IDX_CORE_A];
      core_b_q <= core_clock_out_b_sel ? cnt_out[`PCCS_IDX_CORE_B] : cnt_out[`PCCS_IDX_CORE_A];
      if (ext_clock_used) begin
        // external divider only to the pin
        pin_out_q <= cnt_out[`PCCS_IDX_EXT];
        pin_oe_q <= 1'b1;
      end else begin
        pin_out_q <= gpio_out;
        pin_oe_q <= gpio_oe;
      end
    end
  end

  // pin input passes two flip-flops
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gpio_meta_q <= 1'b0;
      gpio_sync_q <= 1'b0;
    end else begin
      gpio_meta_q <= ext_pin_in;
      gpio_sync_q <= gpio_meta_q;
    end
  end

  // divider a at tap zero, init zero is the reference
  assign core_clock_out_a = core_a_q;
  assign core_clock_out_b = core_b_q;
  assign ext_pin_out = pin_out_q;
  assign ext_pin_oe = pin_oe_q;
  assign gpio_in = gpio_sync_q;

endmodule // pccs_top

// ### test/pccs_chk_sva.sv
// concurrent checks on the ports of the clock synthesizer counter block
module pccs_chk #(
  parameter LEN_W = 8,
  parameter [7:0] NOMINAL_TAP_LEN = 8'h04
) (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // loop control
  input wire counter_reset,
  input wire run_enable,
  input wire pd_gate,
  // shared external pin
  input wire ext_clock_used,
  input wire gpio_out,
  input wire gpio_oe,
  input wire ext_pin_in,
  input wire ext_pin_out,
  input wire ext_pin_oe,
  input wire gpio_in,
  // synthesized clocks and status
  input wire core_clock_out_a,
  input wire core_clock_out_b,
  input wire locked,
  input wire [LEN_W-1:0] osc_tap_len
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // assertions, all in the clk domain
  // ----
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // four cycles allow for the divider flop and the output register
  chk_reset_clears: assert property (counter_reset [*4] |-> !core_clock_out_a &&
    !core_clock_out_b && !locked) else $error("outputs not cleared by counter reset");
  chk_run_hold: assert property (!run_enable [*4] |-> !core_clock_out_a &&
    !core_clock_out_b && !locked) else $error("outputs not held low while disabled");
  chk_tap_restore: assert property (counter_reset [*2] |->
    osc_tap_len == NOMINAL_TAP_LEN) else $error("tap length not restored");
  chk_gate_freeze: assert property ((!pd_gate && !counter_reset) [*3] |=>
    $stable(osc_tap_len)) else $error("tap length moved with detector gated");
  // corrections move the tap length one step at a time
  chk_tap_step: assert property ($changed(osc_tap_len) && !$past(counter_reset) &&
    !$past(counter_reset, 2) |-> osc_tap_len == $past(osc_tap_len) + 1'b1 ||
    osc_tap_len == $past(osc_tap_len) - 1'b1) else $error("tap length step not one");
  chk_gpio_path: assert property (!ext_clock_used ##1 !ext_clock_used |->
    ext_pin_out == $past(gpio_out) && ext_pin_oe == $past(gpio_oe))
    else $error("pin does not follow user drive");
  chk_ext_drive: assert property (ext_clock_used [*2] |-> ext_pin_oe)
    else $error("pin not driven by external divider");
  chk_pin_sync: assert property (gpio_in == $past(ext_pin_in, 2))
    else $error("pin input copy wrong");
  cover property ($rose(locked));
  cover property ($changed(osc_tap_len));
  cover property (ext_clock_used && $rose(ext_pin_out));
endmodule // pccs_chk

bind pccs_top pccs_chk #(.LEN_W(LEN_W), .NOMINAL_TAP_LEN(NOMINAL_TAP_LEN)) u_chk (
  .clk, .rst_b, .counter_reset, .run_enable, .pd_gate, .ext_clock_used, .gpio_out,
  .gpio_oe, .ext_pin_in, .ext_pin_out, .ext_pin_oe, .gpio_in, .core_clock_out_a,
  .core_clock_out_b, .locked, .osc_tap_len
);

// ### test/pccs_core_model.sv
// core logic model that times one synthesized clock in clk cycles
module pccs_core_model (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // watched clock
  input wire clk_in,
  // measurements
  output wire rise,
  output logic [15:0] hi_q,
  output logic [15:0] per_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_q; // level at the last edge
  logic [15:0] cnt_q; // cycles since the last rise
  // rise seen in the current cycle
  assign rise = clk_in && !prev_q;
  // high time latched at each fall, period at each rise
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_q <= 1'b0;
      cnt_q <= 16'h0000;
      hi_q <= 16'h0000;
      per_q <= 16'h0000;
    end else begin
      prev_q <= clk_in;
      cnt_q <= rise ? 16'h0001 : cnt_q + 16'h0001;
      if (rise) per_q <= cnt_q;
      if (!clk_in && prev_q) hi_q <= cnt_q;
    end
  end
endmodule // pccs_core_model

// ### test/tb_top.sv
// self-checking bench for the clock synthesizer counter block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] TAP = 8'h02; // short tap step keeps the run brief
  logic clk, rst_b, counter_reset, run_enable, pd_gate, ref_clk_pin, ext_clock_used;
  logic core_clock_out_a_sel, core_clock_out_b_sel, gpio_out, gpio_oe, ext_pin_in;
  logic [5:0] prescale_value, mult_value;
  logic [5:0] ref_q = 6'h00; // reference pin divider, one driver only
  logic [5:0] dv[3], di[3]; // divide value and initial count of a, b, ext
  logic [6:0] dh[3], dl[3]; // high and low half periods
  logic [2:0] dt[3]; // phase tap
  logic dn[3]; // inversion
  wire ext_pin_out, ext_pin_oe, gpio_in, core_clock_out_a, core_clock_out_b, locked;
  wire [7:0] osc_tap_len;
  wire ra, rb, re; // rise strobes
  wire [15:0] ha, pa, hb, pb, he, pe; // high times and periods
  logic [15:0] d; // measured lag
  int n_errors = 0;
  int num_checks = 0;
  // divider cases: value, high, low, invert, expected high time and period
  int g_t[6] = '{3, 3, 3, 0, 40, 1};
  int h_t[6] = '{2, 2, 2, 1, 32, 1};
  int l_t[6] = '{4, 2, 4, 1, 32, 1};
  int v_t[6] = '{0, 0, 1, 0, 0, 0};
  int eh_t[6] = '{16, 24, 32, 8, 256, 8};
  int ep_t[6] = '{48, 48, 48, 16, 512, 16};
  // phase cases: tap, initial count, expected lag
  int t_t[5] = '{0, 3, 7, 0, 5};
  int i_t[5] = '{0, 0, 0, 1, 3};
  int e_t[5] = '{0, 6, 14, 48, 26};
  pccs_top #(.NOMINAL_TAP_LEN(TAP)) dut (
    .clk, .rst_b, .counter_reset, .run_enable, .pd_gate, .ref_clk_pin, .prescale_value,
    .mult_value, .core_clock_out_a_sel, .core_clock_out_b_sel, .ext_clock_used, .gpio_out,
    .gpio_oe, .ext_pin_in, .ext_pin_out, .ext_pin_oe, .gpio_in, .core_clock_out_a,
    .core_clock_out_b, .locked, .osc_tap_len,
    .core_post_divider_a_value(dv[0]), .core_post_divider_a_high(dh[0]),
    .core_post_divider_a_low(dl[0]), .core_post_divider_a_init(di[0]),
    .core_post_divider_a_tap(dt[0]), .core_post_divider_a_invert(dn[0]),
    .core_post_divider_b_value(dv[1]), .core_post_divider_b_high(dh[1]),
    .core_post_divider_b_low(dl[1]), .core_post_divider_b_init(di[1]),
    .core_post_divider_b_tap(dt[1]), .core_post_divider_b_invert(dn[1]),
    .ext_post_divider_value(dv[2]), .ext_post_divider_high(dh[2]),
    .ext_post_divider_low(dl[2]), .ext_post_divider_init(di[2]),
    .ext_post_divider_tap(dt[2]), .ext_post_divider_invert(dn[2])
  );
  pccs_core_model mon_a (.clk, .rst_b, .clk_in(core_clock_out_a), .rise(ra), .hi_q(ha), .per_q(pa));
  pccs_core_model mon_b (.clk, .rst_b, .clk_in(core_clock_out_b), .rise(rb), .hi_q(hb), .per_q(pb));
  pccs_core_model mon_e (.clk, .rst_b, .clk_in(ext_pin_out), .rise(re), .hi_q(he), .per_q(pe));
  // ----
  // clocks and tasks
  // ----
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // reference pin with a period of 64 clk
  always @(posedge clk) begin
    ref_q <= ref_q + 6'h01;
    ref_clk_pin <= ref_q[5];
  end
  task automatic chk(input logic [15:0] seen, input int exp);
    num_checks++;
    if (seen !== 16'(exp)) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, 16'(exp));
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic set_div(input int k, g, h, l, i, t, v);
    @(posedge clk);
    dv[k] <= 6'(g);
    dh[k] <= 7'(h);
    dl[k] <= 7'(l);
    di[k] <= 6'(i);
    dt[k] <= 3'(t);
    dn[k] <= 1'(v);
  endtask
  // hold long enough for every divider to restart together
  task automatic restart;
    @(posedge clk);
    counter_reset <= 1'b1;
    cyc(5);
    counter_reset <= 1'b0;
  endtask
  // cycles from a rise on output a to the next rise on output b
  task automatic lag;
    d = 16'h0000;
    @(negedge clk);
    repeat (300) if (ra !== 1'b1) @(negedge clk);
    while (rb !== 1'b1 && d < 16'h012C) begin
      d = d + 16'h0001;
      @(negedge clk);
    end
    chk(re, 1);
  endtask
  task automatic stop_test;
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // the tests need under 8000 cycles
  initial begin
    cyc(40000);
    n_errors++;
    stop_test;
  end
  // ----
  // tests
  // ----
  initial begin
    {rst_b, counter_reset, pd_gate, gpio_out, gpio_oe, ext_pin_in} = 6'h00;
    {run_enable, ext_clock_used, core_clock_out_a_sel, core_clock_out_b_sel} = 4'h C;
    // settings keep the oscillator in range
    prescale_value = 6'h01;
    mult_value = 6'h04;
    for (int k = 0; k < 3; k++) begin
      {dv[k], di[k], dh[k], dl[k], dt[k], dn[k]} = {6'h02, 6'h00, 7'h02, 7'h02, 3'h0, 1'b0};
    end
    cyc(10);
    rst_b <= 1'b1;
    @(negedge clk);
    chk(osc_tap_len, TAP);
    chk(locked, 0);
    // both core outputs on divider a
    // third case inverts low duty
    for (int j = 0; j < 6; j++) begin
      set_div(0, g_t[j], h_t[j], l_t[j], 0, 0, v_t[j]);
      restart;
      cyc(3 * ep_t[j] + 20);
      @(negedge clk);
      chk(ha, eh_t[j]);
      chk(pa, ep_t[j]);
      chk(pb, ep_t[j]);
    end
    @(posedge clk);
    core_clock_out_a_sel <= 1'b1;
    core_clock_out_b_sel <= 1'b1;
    cyc(100);
    @(negedge clk);
    chk(pa, 32);
    chk(pe, 32);
    chk(he, 16);
    // tap and initial count offsets against divider a at zero shift
    set_div(0, 4, 4, 4, 0, 0, 0);
    core_clock_out_a_sel <= 1'b0;
    for (int j = 0; j < 5; j++) begin
      set_div(1, 4, 4, 4, i_t[j], t_t[j], 0);
      set_div(2, 4, 4, 4, i_t[j], t_t[j], 0);
      restart;
      cyc(100);
      lag;
      chk(d, e_t[j]);
    end
    @(posedge clk);
    prescale_value <= 6'h02;
    mult_value <= 6'h08;
    pd_gate <= 1'b1;
    restart;
    repeat (3000) if (locked !== 1'b1) @(negedge clk);
    chk(locked, 1);
    @(posedge clk);
    run_enable <= 1'b0;
    cyc(20);
    @(negedge clk);
    chk(core_clock_out_a, 0);
    chk(locked, 0);
    chk(osc_tap_len, TAP);
    @(posedge clk);
    run_enable <= 1'b1;
    repeat (3000) if (locked !== 1'b1) @(negedge clk);
    chk(locked, 1);
    @(posedge clk);
    mult_value <= 6'h09;
    repeat (2000) if (osc_tap_len !== 8'h01) @(negedge clk);
    chk(osc_tap_len, 1);
    @(posedge clk);
    pd_gate <= 1'b0;
    cyc(400);
    @(negedge clk);
    chk(osc_tap_len, 1);
    chk(locked, 0);
    restart;
    @(negedge clk);
    chk(osc_tap_len, TAP);
    @(posedge clk);
    {ext_clock_used, gpio_out, gpio_oe, ext_pin_in} <= 4'h7;
    cyc(4);
    @(negedge clk);
    chk(ext_pin_out, 1);
    chk(ext_pin_oe, 1);
    chk(gpio_in, 1);
    stop_test;
  end
endmodule // tb_top
